// file: inc/scc_pkg.sv
package scc_pkg;

  // ******************************
  // bus and clock
  // ******************************
  localparam int unsigned HCLK_FREQ_HZ = 50_000_000;
  localparam int unsigned ADDR_W       = 8;
  localparam int unsigned DATA_W       = 32;

  // ******************************
  // register byte offsets
  // ******************************
  localparam logic [7:0] OFF_PRESCALER_SELECT = 8'h00;
  localparam logic [7:0] OFF_CHANNEL_START    = 8'h04;
  localparam logic [7:0] OFF_CHANNEL_STOP     = 8'h08;
  localparam logic [7:0] OFF_CHANNEL_ENABLE   = 8'h0c;
  localparam logic [7:0] OFF_SYS_CLOCK_CTRL   = 8'h10;
  localparam logic [7:0] OFF_CHAN_BASE        = 8'h20;
  localparam logic [7:0] OFF_CHAN_STRIDE      = 8'h10;
  localparam logic [3:0] OFF_CHAN_MODE        = 4'h0;
  localparam logic [3:0] OFF_CHAN_DATA        = 4'h4;
  localparam logic [3:0] OFF_CHAN_STATUS      = 4'h8;
  localparam logic [3:0] OFF_CHAN_CLEAR       = 4'hc;

  // ******************************
  // fields
  // ******************************
  localparam int unsigned PRS_A_LSB        = 0;
  localparam int unsigned PRS_B_LSB        = 4;
  localparam int unsigned PRS_W            = 4;
  localparam int unsigned STOP_W           = 4;
  localparam int unsigned MODE_CKS_BIT     = 0;
  localparam int unsigned STAT_OVERRUN_BIT = 0;
  localparam int unsigned STAT_BFULL_BIT   = 5;
  localparam int unsigned STAT_W           = 6;
  localparam int unsigned SYSCLK_SEL_W     = 2;
  localparam int unsigned WORD_W           = 8;

  // ******************************
  // reset values and patterns
  // ******************************
  localparam logic [7:0]              RST_PRESCALER = 8'h00;
  localparam logic [SYSCLK_SEL_W-1:0] RST_SYSCLK    = 2'h0;
  localparam logic [STOP_W-1:0]       STOP_ALL      = 4'hf;
  localparam logic [WORD_W-1:0]       RST_DATA      = 8'h00;

  typedef enum logic [1:0] {
    DP_IDLE,
    DP_READ,
    DP_WRITE
  } scc_dphase_t;

endpackage

// file: src/scc_prescaler.sv
module scc_prescaler
  import scc_pkg::*;
#(
  parameter int unsigned CNT_W = 15
) (
  // clock and reset
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              ce,
  // control
  input  wire logic [PRS_W-1:0]  code,
  // output
  output logic                   tick
);

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [CNT_W-1:0] mask;

  // tick once every 2**code cycles
  always_comb begin
    cnt_nxt = cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
    mask    = CNT_W'((32'h1 << code) - 32'h1);
    tick    = ce && ((cnt_r & mask) == mask);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= '0;
    end else if (ce) begin
      cnt_r <= cnt_nxt;
    end
  end

endmodule

// file: src/scc_channel.sv
module scc_channel
  import scc_pkg::*;
(
  // clock and reset
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              ce,
  // register access
  input  wire logic              mode_wr,
  input  wire logic              mode_val,
  input  wire logic              data_rd,
  input  wire logic              clear_wr,
  input  wire logic [STAT_W-1:0] clear_val,
  // receive side
  input  wire logic              rx_done,
  input  wire logic [WORD_W-1:0] rx_word,
  // clocking
  input  wire logic              running,
  input  wire logic              tick_a,
  input  wire logic              tick_b,
  // state
  output logic                   cks_r,
  output logic [WORD_W-1:0]      data_r,
  output logic [STAT_W-1:0]      status,
  output logic                   op_tick
);

  logic              bfull_r;
  logic              bfull_nxt;
  logic              ovr_r;
  logic              ovr_nxt;
  logic              cks_nxt;
  logic [WORD_W-1:0] data_nxt;

  always_comb begin
    cks_nxt  = mode_wr ? mode_val : cks_r;
    data_nxt = data_r;
    bfull_nxt = bfull_r;
    ovr_nxt  = ovr_r;
    if (data_rd) begin
      bfull_nxt = 1'b0;
    end
    if (clear_wr && clear_val[STAT_OVERRUN_BIT]) begin
      ovr_nxt = 1'b0;
    end
    if (rx_done) begin
      data_nxt  = rx_word;
      bfull_nxt = 1'b1;
      // set wins over a clear in the same cycle
      if (bfull_r && !data_rd) begin
        ovr_nxt = 1'b1;
      end
    end
    status = '0;
    status[STAT_OVERRUN_BIT] = ovr_r;
    status[STAT_BFULL_BIT]   = bfull_r;
    op_tick = running && (cks_r ? tick_b : tick_a);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cks_r   <= 1'b0;
      data_r  <= RST_DATA;
      bfull_r <= 1'b0;
      ovr_r   <= 1'b0;
    end else if (ce) begin
      cks_r   <= cks_nxt;
      data_r  <= data_nxt;
      bfull_r <= bfull_nxt;
      ovr_r   <= ovr_nxt;
    end
  end

endmodule

// file: src/scc_top.sv
module scc_top
  import scc_pkg::*;
#(
  parameter int unsigned CHANNELS = 2,
  parameter int unsigned PRS_CNT_W = 15
) (
  // clock, reset, enable
  input  wire logic                       hclk,
  input  wire logic                       hresetn,
  input  wire logic                       ce,
  // ahb-lite slave
  input  wire logic                       hsel,
  input  wire logic [ADDR_W-1:0]          haddr,
  input  wire logic [1:0]                 htrans,
  input  wire logic                       hwrite,
  input  wire logic [2:0]                 hsize,
  input  wire logic [DATA_W-1:0]          hwdata,
  input  wire logic                       hready,
  output logic      [DATA_W-1:0]          hrdata,
  output logic                            hreadyout,
  output logic                            hresp,
  // receive side of the shift logic
  input  wire logic [CHANNELS-1:0]        rx_done,
  input  wire logic [CHANNELS-1:0][WORD_W-1:0] rx_word,
  // clocking and control outputs
  output logic      [CHANNELS-1:0]        op_clk_tick,
  output logic      [CHANNELS-1:0]        channel_running,
  output logic      [SYSCLK_SEL_W-1:0]    sys_clk_sel
);

  // ****************************************
  // bus address phase
  // ****************************************
  scc_dphase_t           dp_r;
  scc_dphase_t           dp_nxt;
  logic [ADDR_W-1:0]     daddr_r;
  logic [ADDR_W-1:0]     daddr_nxt;
  logic [DATA_W-1:0]     rdata_r;
  logic [DATA_W-1:0]     rdata_nxt;
  logic                  take;
  logic                  take_rd;
  logic [DATA_W-1:0]     rd_mux;

  // registers
  logic [7:0]            prs_r;
  logic [7:0]            prs_nxt;
  logic [STOP_W-1:0]     run_r;
  logic [STOP_W-1:0]     run_nxt;
  logic [SYSCLK_SEL_W-1:0] sysclk_r;
  logic [SYSCLK_SEL_W-1:0] sysclk_nxt;

  // channel strobes and channel outputs
  logic [CHANNELS-1:0]   mode_wr;
  logic [CHANNELS-1:0]   data_rd;
  logic [CHANNELS-1:0]   clear_wr;
  logic [CHANNELS-1:0]   cks;
  logic [CHANNELS-1:0][WORD_W-1:0] chan_data;
  logic [CHANNELS-1:0][STAT_W-1:0] chan_stat;

  logic                  tick_a;
  logic                  tick_b;
  logic                  wr_act;

  logic                  unit_stopped;
  logic [STOP_W-1:0]     chan_mask;

  // decoded write strobes, data phase
  logic                  wr_prs;
  logic                  wr_start;
  logic                  wr_stop;
  logic                  wr_sysclk;

  // per-channel register hits
  logic [CHANNELS-1:0]   hit_mode_a;
  logic [CHANNELS-1:0]   hit_data_a;
  logic [CHANNELS-1:0]   hit_stat_a;
  logic [CHANNELS-1:0]   hit_mode_d;
  logic [CHANNELS-1:0]   hit_clear_d;

  // ****************************************
  // bus outputs
  // ****************************************

  // bus waits while the block is frozen
  assign hreadyout = ce;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_r;

  assign take    = ce && hsel && hready && htrans[1];
  assign take_rd = take && !hwrite;
  assign wr_act  = ce && (dp_r == DP_WRITE);

  // ****************************************
  // address decode helpers
  // ****************************************
  function automatic logic chan_hit(input logic [ADDR_W-1:0] a,
                                    input int unsigned ch,
                                    input logic [3:0] sub);
    logic [ADDR_W-1:0] base;
    base = OFF_CHAN_BASE + ADDR_W'(ch) * OFF_CHAN_STRIDE;
    return a == (base | {4'h0, sub});
  endfunction

  // ****************************************
  // per-channel address hits
  // ****************************************
  always_comb begin
    hit_mode_a  = '0;
    hit_data_a  = '0;
    hit_stat_a  = '0;
    hit_mode_d  = '0;
    hit_clear_d = '0;
    for (int unsigned c = 0; c < CHANNELS; c++) begin
      hit_mode_a[c]  = chan_hit(haddr, c, OFF_CHAN_MODE);
      hit_data_a[c]  = chan_hit(haddr, c, OFF_CHAN_DATA);
      hit_stat_a[c]  = chan_hit(haddr, c, OFF_CHAN_STATUS);
      hit_mode_d[c]  = chan_hit(daddr_r, c, OFF_CHAN_MODE);
      hit_clear_d[c] = chan_hit(daddr_r, c, OFF_CHAN_CLEAR);
    end
  end

  // ****************************************
  // read mux, sampled in the address phase
  // ****************************************
  always_comb begin
    rd_mux = '0;
    unique case (haddr)
      OFF_PRESCALER_SELECT: rd_mux[7:0]          = prs_r;
      OFF_CHANNEL_ENABLE:   rd_mux[STOP_W-1:0]   = run_r;
      OFF_SYS_CLOCK_CTRL:   rd_mux[SYSCLK_SEL_W-1:0] = sysclk_r;
      default:              rd_mux = '0;
    endcase
    for (int unsigned c = 0; c < CHANNELS; c++) begin
      if (hit_mode_a[c]) begin
        rd_mux = '0;
        rd_mux[MODE_CKS_BIT] = cks[c];
      end
      if (hit_data_a[c]) begin
        rd_mux = {{(DATA_W-WORD_W){1'b0}}, chan_data[c]};
      end
      if (hit_stat_a[c]) begin
        rd_mux = {{(DATA_W-STAT_W){1'b0}}, chan_stat[c]};
      end
    end
  end

  // ****************************************
  // bus phase tracking
  // ****************************************
  always_comb begin
    dp_nxt    = dp_r;
    daddr_nxt = daddr_r;
    rdata_nxt = rdata_r;
    if (ce) begin
      if (take) begin
        dp_nxt    = hwrite ? DP_WRITE : DP_READ;
        daddr_nxt = haddr;
      end else if (hready) begin
        dp_nxt = DP_IDLE;
      end
      if (take_rd) begin
        rdata_nxt = rd_mux;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_r    <= DP_IDLE;
      daddr_r <= '0;
      rdata_r <= '0;
    end else begin
      dp_r    <= dp_nxt;
      daddr_r <= daddr_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ****************************************
  // write decode, data phase
  // ****************************************
  always_comb begin
    wr_prs    = 1'b0;
    wr_start  = 1'b0;
    wr_stop   = 1'b0;
    wr_sysclk = 1'b0;
    if (wr_act) begin
      unique case (daddr_r)
        OFF_PRESCALER_SELECT: wr_prs    = 1'b1;
        OFF_CHANNEL_START:    wr_start  = 1'b1;
        OFF_CHANNEL_STOP:     wr_stop   = 1'b1;
        OFF_SYS_CLOCK_CTRL:   wr_sysclk = 1'b1;
        default: begin
          wr_prs = 1'b0;
        end
      endcase
    end
  end

  // run bits exist only for the channels that are built
  always_comb begin
    chan_mask = '0;
    for (int unsigned c = 0; c < STOP_W; c++) begin
      chan_mask[c] = (c < CHANNELS);
    end
  end

  // unit counts as stopped once every run bit is clear
  assign unit_stopped = ((run_r & STOP_ALL) == '0);

  // ****************************************
  // global registers
  // ****************************************
  always_comb begin
    prs_nxt    = prs_r;
    run_nxt    = run_r;
    sysclk_nxt = sysclk_r;
    if (wr_prs) begin
      prs_nxt = hwdata[7:0];
    end
    if (wr_start) begin
      run_nxt = run_r | hwdata[STOP_W-1:0];
    end
    if (wr_stop) begin
      run_nxt = run_r & ~hwdata[STOP_W-1:0];
    end
    // change only taken with the whole unit stopped
    if (wr_sysclk && unit_stopped) begin
      sysclk_nxt = hwdata[SYSCLK_SEL_W-1:0];
    end
    run_nxt = run_nxt & chan_mask;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prs_r    <= RST_PRESCALER;
      run_r    <= '0;
      sysclk_r <= RST_SYSCLK;
    end else if (ce) begin
      prs_r    <= prs_nxt;
      run_r    <= run_nxt;
      sysclk_r <= sysclk_nxt;
    end
  end

  // ****************************************
  // control outputs
  // ****************************************

  assign sys_clk_sel     = sysclk_r;
  assign channel_running = run_r[CHANNELS-1:0];

  // ****************************************
  // prescalers
  // ****************************************
  scc_prescaler #(
    .CNT_W (PRS_CNT_W)
  ) u_prs_a (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ce      (ce),
    .code    (prs_r[PRS_A_LSB +: PRS_W]),
    .tick    (tick_a)
  );

  scc_prescaler #(
    .CNT_W (PRS_CNT_W)
  ) u_prs_b (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ce      (ce),
    .code    (prs_r[PRS_B_LSB +: PRS_W]),
    .tick    (tick_b)
  );

  // ****************************************
  // channels
  // ****************************************
  always_comb begin
    for (int unsigned c = 0; c < CHANNELS; c++) begin
      mode_wr[c]  = wr_act && hit_mode_d[c];
      clear_wr[c] = wr_act && hit_clear_d[c];
      data_rd[c]  = take_rd && hit_data_a[c];
    end
  end

  for (genvar g = 0; g < CHANNELS; g++) begin : g_chan
    scc_channel u_chan (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .ce        (ce),
      .mode_wr   (mode_wr[g]),
      .mode_val  (hwdata[MODE_CKS_BIT]),
      .data_rd   (data_rd[g]),
      .clear_wr  (clear_wr[g]),
      .clear_val (hwdata[STAT_W-1:0]),
      .rx_done   (rx_done[g]),
      .rx_word   (rx_word[g]),
      .running   (run_r[g]),
      .tick_a    (tick_a),
      .tick_b    (tick_b),
      .cks_r     (cks[g]),
      .data_r    (chan_data[g]),
      .status    (chan_stat[g]),
      .op_tick   (op_clk_tick[g])
    );
  end

endmodule

// file: tb/scc_rx_model.sv
module scc_rx_model
  import scc_pkg::*;
#(
  parameter int unsigned CHANNELS = 2
) (
  // clock
  input  wire logic                       hclk,
  // received words
  output logic [CHANNELS-1:0]             rx_done,
  output logic [CHANNELS-1:0][WORD_W-1:0] rx_word
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    rx_done = '0;
    rx_word = '0;
  end

  // one-cycle completion; word is not held afterwards
  task automatic send(input int ch, input logic [WORD_W-1:0] w);
    @(posedge hclk);
    rx_done[ch] <= 1'b1;
    rx_word[ch] <= w;
    @(posedge hclk);
    rx_done[ch] <= 1'b0;
    rx_word[ch] <= ~w;
  endtask
endmodule

// file: tb/scc_top_props.sv
module scc_top_props
  import scc_pkg::*;
#(
  parameter int unsigned CHANNELS = 2
) (
  input wire logic                hclk,
  input wire logic                hresetn,
  input wire logic                ce,
  input wire logic                hsel,
  input wire logic [ADDR_W-1:0]   haddr,
  input wire logic [1:0]          htrans,
  input wire logic                hwrite,
  input wire logic [DATA_W-1:0]   hwdata,
  input wire logic                hready,
  input wire logic [DATA_W-1:0]   hrdata,
  input wire logic                hreadyout,
  input wire logic                hresp,
  input wire logic [CHANNELS-1:0] op_clk_tick,
  input wire logic [CHANNELS-1:0] channel_running,
  input wire logic [SYSCLK_SEL_W-1:0] sys_clk_sel
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic take;
  assign take = ce && hsel && hready && htrans[1];

  sequence s_stop_all;
    take && hwrite && haddr == OFF_CHANNEL_STOP ##1 hwdata[STOP_W-1:0] == STOP_ALL;
  endsequence

  chk_resp_okay: assert property (hresp == 1'b0) else $error("bad hresp");
  chk_ready_ce: assert property (hreadyout == ce) else $error("hreadyout not ce");
  chk_tick_gated: assert property ((op_clk_tick & ~channel_running) == '0)
    else $error("tick while stopped");
  chk_rdata_hold: assert property ($changed(hrdata) |-> $past(take && !hwrite))
    else $error("hrdata moved without read");
  chk_run_write: assert property ($changed(channel_running) |-> $past(take && hwrite, 2))
    else $error("run state moved without write");
  chk_clk_stopped: assert property ($changed(sys_clk_sel) |-> $past(channel_running) == '0)
    else $error("clock select changed while running");
  chk_stop_all: assert property (s_stop_all |=> channel_running == '0 && op_clk_tick == '0)
    else $error("stop all left a channel running");
  chk_frozen_state: assert property (!ce |=> $stable(channel_running) && $stable(hrdata))
    else $error("state moved while frozen");
  chk_frozen_tick: assert property (!ce |-> op_clk_tick == '0)
    else $error("tick while frozen");
endmodule

bind scc_top scc_top_props #(.CHANNELS(CHANNELS)) u_props (.hclk, .hresetn, .ce, .hsel, .haddr,
  .htrans, .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .op_clk_tick,
  .channel_running, .sys_clk_sel);

// file: tb/scc_top_tb.sv
module scc_top_tb;
  import scc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic hclk, hresetn, ce, hsel, hwrite, hready, hreadyout, hresp;
  logic [ADDR_W-1:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [DATA_W-1:0] hwdata, hrdata;
  logic [1:0] rx_done, op_clk_tick, channel_running;
  logic [1:0][WORD_W-1:0] rx_word;
  logic [SYSCLK_SEL_W-1:0] sys_clk_sel;
  int errors, samples_checked, cycles;

  assign hready = hreadyout;

  scc_top #(.CHANNELS(2)) dut (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hrdata, .hreadyout, .hresp, .rx_done, .rx_word, .op_clk_tick,
    .channel_running, .sys_clk_sel);
  scc_rx_model #(.CHANNELS(2)) peer (.hclk, .rx_done, .rx_word);

  always #10 hclk = ~hclk;

  // ******************************
  // tasks
  // ******************************
  task automatic give_verdict();
    if (errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("mismatch at %0t: expected %h got %h", $time, e, g);
    end
  endtask

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    check(e, r);
  endtask

  // gap between ticks of one channel, after the divider settles
  task automatic period(input int ch, input int k);
    int n;
    repeat (3) begin
      n = 0;
      do begin
        @(posedge hclk);
        n++;
      end while (op_clk_tick[ch] !== 1'b1);
    end
    check(32'h1 << k, 32'(n));
  endtask

  always @(posedge hclk) begin
    cycles++;
    if (cycles == 90000) begin
      errors++;
      give_verdict();
    end
  end

  // ******************************
  // tests
  // ******************************
  initial begin
    {hclk, hresetn, hwrite, hwdata, haddr, htrans} = '0;
    {ce, hsel} = 2'b11;
    hsize = 3'h2;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    rd(8'h00, 32'h0);
    rd(8'h24, 32'h0);
    rd(8'hfc, 32'h0);
    wr(8'h04, 32'h3);
    rd(8'h0c, 32'h3);
    wr(8'h10, 32'h2);
    rd(8'h10, 32'h0);
    peer.send(0, 8'ha5);
    rd(8'h28, 32'h20);
    peer.send(0, 8'h3c);
    rd(8'h28, 32'h21);
    wr(8'h2c, 32'h0);
    rd(8'h28, 32'h21);
    rd(8'h24, 32'h3c);
    rd(8'h28, 32'h01);
    wr(8'h2c, 32'h01);
    rd(8'h28, 32'h00);
    peer.send(0, 8'h11);
    peer.send(0, 8'h22);
    wr(8'h2c, 32'h0);
    rd(8'h28, 32'h21);
    rd(8'h24, 32'h22);
    wr(8'h2c, 32'h21);
    rd(8'h28, 32'h00);
    // overrun after the status read must survive the clear
    peer.send(0, 8'h44);
    rd(8'h28, 32'h20);
    peer.send(0, 8'h55);
    wr(8'h2c, 32'h20);
    rd(8'h28, 32'h21);
    rd(8'h24, 32'h55);
    wr(8'h2c, 32'h21);
    rd(8'h28, 32'h00);
    // frozen block ignores a received word
    ce <= 1'b0;
    peer.send(0, 8'h77);
    check(32'h0, 32'(hreadyout));
    ce <= 1'b1;
    rd(8'h28, 32'h00);
    peer.send(1, 8'h5a);
    rd(8'h34, 32'h5a);
    rd(8'h38, 32'h00);
    for (int k = 0; k < 12; k++) begin
      wr(8'h00, 32'((k << 4) | (11 - k)));
      wr(8'h20, 32'h0);
      period(0, 11 - k);
      wr(8'h20, 32'h1);
      period(0, k);
    end
    period(1, 0);
    wr(8'h30, 32'h1);
    rd(8'h30, 32'h1);
    period(1, 11);
    wr(8'h08, 32'hf);
    rd(8'h0c, 32'h0);
    check(32'h0, 32'({channel_running, op_clk_tick}));
    wr(8'h10, 32'h2);
    rd(8'h10, 32'h2);
    check(32'h2, 32'(sys_clk_sel));
    give_verdict();
  end
endmodule
